// file: logic/ocd_defs.svh
`ifndef OCD_DEFS_SVH
`define OCD_DEFS_SVH
// **********************************
// opcode values
// **********************************
`define OCD_OP_NOP      8'h00
`define OCD_OP_HALT     8'h76
`define OCD_OP_MASKI    8'hF3
`define OCD_OP_UNMASKI  8'hFB
`define OCD_OP_EX_AF    8'h08
`define OCD_OP_EX_ALT   8'hD9
`define OCD_OP_EX_DE    8'hEB
`define OCD_OP_EX_SP    8'hE3
`define OCD_OP_OUT_N    8'hD3
`define OCD_OP_IN_N     8'hDB
`define OCD_OP_JP       8'hC3
`define OCD_OP_CALL     8'hCD
`define OCD_OP_LD_PTR   8'h21
`define OCD_OP_MEM_INC  8'h34
`define OCD_OP_MEM_DEC  8'h35
`define OCD_OP_MEM_LDN  8'h36
`define OCD_PFX_BIT     8'hCB
`define OCD_PFX_EXT     8'hED
`define OCD_PFX_IDX1    8'hDD
`define OCD_PFX_IDX2    8'hFD
`define OCD_EXT_RETURN_FROM_NONMASKABLE    8'h45
`define OCD_EXT_RETURN_FROM_MASKABLE    8'h4D
`define OCD_EXT_IRS0    8'h46
`define OCD_EXT_IRS1    8'h56
`define OCD_EXT_IRS2    8'h5E
// **********************************
// field values
// **********************************
`define OCD_R_MEM       3'h6
`define OCD_Y_NO_SHIFT  3'h6
// defined second bytes 40-7F of the extended group, bit {z,y}
`define OCD_EXT_DEFINED 64'h350D0301CFFFBFBF
`endif

// file: logic/ocd_pkg.sv
package ocd_pkg;
   typedef enum logic [4:0] {
      CL_NO_OPERATION      = 5'h00,
      CL_HALT              = 5'h01,
      CL_COPY              = 5'h02,
      CL_ALU               = 5'h03,
      CL_ROT_SHIFT         = 5'h04,
      CL_BIT_TEST          = 5'h05,
      CL_BIT_CLEAR         = 5'h06,
      CL_BIT_SET           = 5'h07,
      CL_RESPONSE_SELECT   = 5'h08,
      CL_RET_NONMASKABLE   = 5'h09,
      CL_RET_MASKABLE      = 5'h0A,
      CL_BLOCK             = 5'h0B,
      CL_REL_BRANCH        = 5'h0C,
      CL_RESTART           = 5'h0D,
      CL_MASK_INTERRUPTS   = 5'h0E,
      CL_UNMASK_INTERRUPTS = 5'h0F,
      CL_EXCHANGE          = 5'h10,
      CL_OUT_IMM_PORT      = 5'h11,
      CL_IN_IMM_PORT       = 5'h12,
      CL_PORT_VIA_C        = 5'h13,
      CL_OTHER             = 5'h14
   } ocd_cls_t;
   typedef enum logic [1:0] {
      IDX_NONE   = 2'b00,
      IDX_FIRST  = 2'b01,
      IDX_SECOND = 2'b10
   } ocd_idx_t;
   typedef enum logic [1:0] {
      GRP_MAIN = 2'b00,
      GRP_BIT  = 2'b01,
      GRP_EXT  = 2'b10
   } ocd_grp_t;
   typedef enum logic [2:0] {
      S_OP      = 3'b000,
      S_BIT     = 3'b001,
      S_EXT     = 3'b010,
      S_IBIT_D  = 3'b011,
      S_IBIT_OP = 3'b100,
      S_DISP    = 3'b101,
      S_IMM_LO  = 3'b110,
      S_IMM_HI  = 3'b111
   } ocd_st_t;
   typedef struct packed {
      ocd_cls_t    cls;
      logic        undef;
      logic [1:0]  n_imm;
      logic        disp;
   } ocd_info_t;
   typedef struct packed {
      ocd_cls_t    cls;
      ocd_grp_t    grp;
      ocd_idx_t    idx;
      logic        undef;
      logic [7:0]  opcode;
      logic [2:0]  sel;
      logic [2:0]  src;
      logic [1:0]  irs_mode;
      logic        rpt;
      logic [7:0]  rst_addr;
      logic [7:0]  disp;
      logic [15:0] imm;
   } ocd_dec_t;
endpackage

// file: logic/ocd_decoder.sv
`timescale 1ns/1ns
`include "ocd_defs.svh"
// Notes on behaviour
// [RULE1] Unprefixed 76 is the stop-and-wait operation and 00 is no_operation, one byte each.
// [RULE2] 40-7F except 76 copy register to register, destination in bits 5:3 and source in bits 2:0.
// [RULE3] 80-BF are accumulator operations, group in bits 5:3 and operand register in bits 2:0.
// [RULE4] After CB the second byte is rotate/shift, bit test, bit clear or bit set by its top two bits.
// [RULE5] DD and FD put first_index_register or second_index_register in place of pointer_pair, with a displacement byte for memory forms.
// [RULE6] An index-prefixed bit operation carries its displacement between CB and the final byte.
// [RULE7] ED 46, 56 and 5E pick interrupt response modes 0, 1 and 2.
// [RULE8] ED 45 is return_from_nonmaskable and ED 4D is return_from_maskable, distinct from plain return.
// [RULE9] ED A0-BB are block copy, search, input and output, with B0-BB the repeating forms.
// [RULE10] Relative branches 10, 18, 20, 28, 30 and 38 take one trailing displacement byte.
// [RULE11] C7 to FF in steps of 8 are one-byte restart calls to 0 through 38H.
// [RULE12] F3 is mask_interrupts and FB is unmask_interrupts, one byte each.
// [RULE13] Opcodes with a 16-bit operand take two more bytes, those with an 8-bit operand one.
// [RULE14] D3 and DB move the accumulator to or from an immediate port; ED 40-79 use register C as the port.
// [RULE15] 08, D9, EB and E3 are the exchange operations.
// [RULE16] Byte combinations not in the opcode map are flagged undefined.
module ocd_decoder
(
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             byte_valid,
   input  wire logic [7:0]       byte_data,
   output      logic             dec_valid_q,
   output      ocd_pkg::ocd_dec_t dec_q
);
   import ocd_pkg::*;

   // a literal cannot be bit-selected, so the map lives in a constant
   localparam logic [63:0] EXT_DEFINED = `OCD_EXT_DEFINED;

   // ************************************
   // classification of a final opcode byte
   // ************************************
   function automatic ocd_info_t classify(ocd_grp_t g, ocd_idx_t ix, logic [7:0] op);
      ocd_info_t  r;
      logic [1:0] x;
      logic [2:0] y;
      logic [2:0] z;
      logic       mem;
      logic       ptr;
      r = '{cls: CL_OTHER, undef: 1'b0, n_imm: 2'd0, disp: 1'b0};
      x = op[7:6];
      y = op[5:3];
      z = op[2:0];
      unique case (g)
         GRP_BIT:
         begin
            r.cls = (x == 2'd0) ? CL_ROT_SHIFT : (x == 2'd1) ? CL_BIT_TEST :
                    (x == 2'd2) ? CL_BIT_CLEAR : CL_BIT_SET;                 // see [RULE4]
            r.undef = (x == 2'd0 && y == `OCD_Y_NO_SHIFT) ||
                      (ix != IDX_NONE && z != `OCD_R_MEM);                   // see [RULE16]
         end
         GRP_EXT:
         begin
            if (x == 2'd1)
            begin
               r.undef = !EXT_DEFINED[{z, y}];                               // see [RULE16]
               if (z == 3'd3)
                  r.n_imm = 2'd2;                                            // see [RULE13]
               if (z == 3'd0 || z == 3'd1)
                  r.cls = CL_PORT_VIA_C;                                     // see [RULE14]
               else if (op == `OCD_EXT_RETURN_FROM_NONMASKABLE)
                  r.cls = CL_RET_NONMASKABLE;                                // see [RULE8]
               else if (op == `OCD_EXT_RETURN_FROM_MASKABLE)
                  r.cls = CL_RET_MASKABLE;                                   // see [RULE8]
               else if (z == 3'd6)
                  r.cls = CL_RESPONSE_SELECT;                                // see [RULE7]
            end
            else
            begin
               r.cls = CL_BLOCK;                                             // see [RULE9]
               r.undef = !(x == 2'd2 && y[2] && !z[2]);                      // see [RULE16]
            end
         end
         default:
         begin
            mem = op == `OCD_OP_MEM_INC || op == `OCD_OP_MEM_DEC || op == `OCD_OP_MEM_LDN ||
                  (x == 2'd1 && (y == `OCD_R_MEM || z == `OCD_R_MEM) && op != `OCD_OP_HALT) ||
                  (x == 2'd2 && z == `OCD_R_MEM);
            ptr = (x == 2'd0 && ((z == 3'd1 && y[0]) || op == `OCD_OP_LD_PTR ||
                  ((z == 3'd2 || z == 3'd3) && y[2:1] == 2'b10))) ||
                  (x == 2'd3 && ((z == 3'd1 && (y == 3'd4 || y == 3'd5 || y == 3'd7)) ||
                  (y == 3'd4 && (z == 3'd3 || z == 3'd5))));
            r.disp = ix != IDX_NONE && mem;                                  // see [RULE5]
            r.undef = ix != IDX_NONE && !mem && !ptr;                        // see [RULE16]
            if ((x == 2'd0 && z == 3'd1 && !y[0]) || (x == 2'd0 && z == 3'd2 && y[2]) ||
                (x == 2'd3 && (z == 3'd2 || z == 3'd4)) || op == `OCD_OP_JP || op == `OCD_OP_CALL)
               r.n_imm = 2'd2;                                               // see [RULE13]
            else if (z == 3'd6 && x != 2'd1 && x != 2'd2)
               r.n_imm = 2'd1;                                               // see [RULE13]
            if (op == `OCD_OP_NOP)
               r.cls = CL_NO_OPERATION;                                      // see [RULE1]
            else if (op == `OCD_OP_HALT)
               r.cls = CL_HALT;                                              // see [RULE1]
            else if (x == 2'd1)
               r.cls = CL_COPY;                                              // see [RULE2]
            else if (x == 2'd2)
               r.cls = CL_ALU;                                               // see [RULE3]
            else if (x == 2'd0 && z == 3'd0 && y[2:1] != 2'b00)
            begin
               r.cls = CL_REL_BRANCH;                                        // see [RULE10]
               r.n_imm = 2'd1;
            end
            else if (x == 2'd3 && z == 3'd7)
               r.cls = CL_RESTART;                                           // see [RULE11]
            else if (op == `OCD_OP_MASKI)
               r.cls = CL_MASK_INTERRUPTS;                                   // see [RULE12]
            else if (op == `OCD_OP_UNMASKI)
               r.cls = CL_UNMASK_INTERRUPTS;                                 // see [RULE12]
            else if (op == `OCD_OP_EX_AF || op == `OCD_OP_EX_ALT || op == `OCD_OP_EX_DE ||
                     op == `OCD_OP_EX_SP)
               r.cls = CL_EXCHANGE;                                          // see [RULE15]
            else if (op == `OCD_OP_OUT_N || op == `OCD_OP_IN_N)
            begin
               r.cls = (op == `OCD_OP_OUT_N) ? CL_OUT_IMM_PORT : CL_IN_IMM_PORT; // see [RULE14]
               r.n_imm = 2'd1;
            end
         end
      endcase
      return r;
   endfunction

   ocd_st_t    st_q;
   ocd_st_t    st_d;
   ocd_idx_t   idx_q;
   logic [1:0] need_q;
   ocd_grp_t   grp_now;
   ocd_info_t  info;
   logic       take_op;
   logic       emit;
   logic       is_idx;

   assign is_idx = byte_data == `OCD_PFX_IDX1 || byte_data == `OCD_PFX_IDX2;

   always_comb
   begin
      grp_now = (st_q == S_BIT || st_q == S_IBIT_OP) ? GRP_BIT :
                (st_q == S_EXT) ? GRP_EXT : GRP_MAIN;
      info = classify(grp_now, idx_q, byte_data);
   end

   // ************************************
   // byte sequencing
   // ************************************
   always_comb
   begin
      st_d = st_q;
      take_op = 1'b0;
      emit = 1'b0;
      if (byte_valid)
      begin
         unique case (st_q)
            S_OP:
            begin
               if (is_idx)
                  st_d = S_OP;                                               // see [RULE5]
               else if (byte_data == `OCD_PFX_BIT)
                  st_d = (idx_q == IDX_NONE) ? S_BIT : S_IBIT_D;             // see [RULE6]
               else if (byte_data == `OCD_PFX_EXT)
                  st_d = S_EXT;
               else
                  take_op = 1'b1;
            end
            S_BIT, S_EXT, S_IBIT_OP:
               take_op = 1'b1;
            S_IBIT_D:
               st_d = S_IBIT_OP;                                             // see [RULE6]
            S_DISP:
            begin
               if (need_q == 2'd0)
                  emit = 1'b1;
               else
                  st_d = S_IMM_LO;
            end
            S_IMM_LO:
            begin
               if (need_q == 2'd2)
                  st_d = S_IMM_HI;
               else
                  emit = 1'b1;
            end
            S_IMM_HI:
               emit = 1'b1;
         endcase
      end
      if (take_op)
      begin
         if (info.disp)
            st_d = S_DISP;                                                   // see [RULE5]
         else if (info.n_imm != 2'd0)
            st_d = S_IMM_LO;                                                 // see [RULE13]
         else
            emit = 1'b1;
      end
      if (emit)
         st_d = S_OP;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         st_q <= S_OP;
      else
         st_q <= st_d;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         need_q <= 2'd0;
      else if (take_op)
         need_q <= info.n_imm;
   end

   // index selection lives only until the instruction ends
   always_ff @(posedge clk)
   begin
      if (!rstn || emit)
         idx_q <= IDX_NONE;
      else if (byte_valid && st_q == S_OP && is_idx)
         idx_q <= (byte_data == `OCD_PFX_IDX1) ? IDX_FIRST : IDX_SECOND;     // see [RULE5]
      else if (byte_valid && st_q == S_OP && byte_data == `OCD_PFX_EXT)
         idx_q <= IDX_NONE;
   end

   // ************************************
   // decoded result
   // ************************************
   always_ff @(posedge clk)
   begin
      if (!rstn)
         dec_valid_q <= 1'b0;
      else
         dec_valid_q <= emit;
   end

   // fields fill as bytes arrive; only meaningful while dec_valid_q is high
   always_ff @(posedge clk)
   begin
      if (!rstn)
         dec_q <= '0;
      else if (take_op)
      begin
         dec_q.cls <= info.cls;
         dec_q.undef <= info.undef;
         dec_q.grp <= grp_now;
         dec_q.idx <= idx_q;
         dec_q.opcode <= byte_data;
         dec_q.sel <= byte_data[5:3];                                        // see [RULE2]
         dec_q.src <= byte_data[2:0];                                        // see [RULE3]
         dec_q.irs_mode <= (byte_data == `OCD_EXT_IRS0) ? 2'd0 :
                           (byte_data == `OCD_EXT_IRS1) ? 2'd1 : 2'd2;       // see [RULE7]
         dec_q.rpt <= grp_now == GRP_EXT && byte_data[4];                    // see [RULE9]
         dec_q.rst_addr <= {2'b00, byte_data[5:3], 3'b000};                  // see [RULE11]
         dec_q.imm <= '0;
         if (st_q != S_IBIT_OP)
            dec_q.disp <= '0;
      end
      else if (byte_valid && (st_q == S_IBIT_D || st_q == S_DISP))
         dec_q.disp <= byte_data;                                            // see [RULE6]
      else if (byte_valid && st_q == S_IMM_LO)
         dec_q.imm[7:0] <= byte_data;                                        // see [RULE10]
      else if (byte_valid && st_q == S_IMM_HI)
         dec_q.imm[15:8] <= byte_data;                                       // see [RULE13]
   end

   // ************************************
   // checks
   // ************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_plain_op(logic [7:0] v);
      byte_valid && st_q == S_OP && idx_q == IDX_NONE && byte_data == v;
   endsequence
   sequence s_imm_lo_then_hi;
      (byte_valid && st_q == S_IMM_LO) ##1 (!dec_valid_q && st_q == S_IMM_HI);
   endsequence

   property p_halt;
      s_plain_op(`OCD_OP_HALT) |=> dec_valid_q && dec_q.cls == CL_HALT && !dec_q.undef;
   endproperty
   a_halt: assert property (p_halt) else $error("halt byte not decoded"); // see [RULE1]

   property p_copy;
      byte_valid && st_q == S_OP && idx_q == IDX_NONE && byte_data[7:6] == 2'd1 &&
      byte_data != `OCD_OP_HALT |=> dec_valid_q && dec_q.cls == CL_COPY && dec_q.sel == $past(byte_data[5:3]);
   endproperty
   a_copy: assert property (p_copy) else $error("copy fields wrong"); // see [RULE2]

   property p_alu;
      byte_valid && st_q == S_OP && byte_data[7:6] == 2'd2 && byte_data[2:0] != `OCD_R_MEM
      |=> dec_valid_q && dec_q.cls == CL_ALU && dec_q.src == $past(byte_data[2:0]);
   endproperty
   a_alu: assert property (p_alu) else $error("accumulator op wrong"); // see [RULE3]

   property p_bit_group;
      byte_valid && st_q == S_BIT |=> dec_valid_q && dec_q.grp == GRP_BIT &&
      dec_q.cls == (($past(byte_data[7:6]) == 2'd0) ? CL_ROT_SHIFT : ($past(byte_data[7:6]) == 2'd1) ?
      CL_BIT_TEST : ($past(byte_data[7:6]) == 2'd2) ? CL_BIT_CLEAR : CL_BIT_SET);
   endproperty
   a_bit_group: assert property (p_bit_group) else $error("bit group class wrong"); // see [RULE4]

   sequence s_idx_bit;
      (byte_valid && st_q == S_OP && idx_q != IDX_NONE && byte_data == `OCD_PFX_BIT)
      ##1 (byte_valid && st_q == S_IBIT_D) ##1 (st_q == S_IBIT_OP && !dec_valid_q);
   endsequence
   property p_idx_bit;
      s_idx_bit |-> dec_q.disp == $past(byte_data);
   endproperty
   a_idx_bit: assert property (p_idx_bit) else $error("index bit displacement lost"); // see [RULE6]

   property p_idx_mem;
      byte_valid && st_q == S_OP && idx_q != IDX_NONE && byte_data[7:6] == 2'd2 &&
      byte_data[2:0] == `OCD_R_MEM |=> st_q == S_DISP && !dec_valid_q;
   endproperty
   a_idx_mem: assert property (p_idx_mem) else $error("no displacement stage"); // see [RULE5]

   property p_irs;
      byte_valid && st_q == S_EXT && byte_data == `OCD_EXT_IRS1
      |=> dec_valid_q && dec_q.cls == CL_RESPONSE_SELECT && dec_q.irs_mode == 2'd1;
   endproperty
   a_irs: assert property (p_irs) else $error("response mode wrong"); // see [RULE7]

   property p_returns;
      byte_valid && st_q == S_EXT && (byte_data == `OCD_EXT_RETURN_FROM_NONMASKABLE || byte_data == `OCD_EXT_RETURN_FROM_MASKABLE)
      |=> dec_valid_q && (dec_q.cls == CL_RET_NONMASKABLE) == ($past(byte_data) == `OCD_EXT_RETURN_FROM_NONMASKABLE);
   endproperty
   a_returns: assert property (p_returns) else $error("return kind wrong"); // see [RULE8]

   property p_block;
      byte_valid && st_q == S_EXT && byte_data[7:6] == 2'd2 |=> dec_valid_q && dec_q.cls == CL_BLOCK &&
      dec_q.rpt == $past(byte_data[4]);
   endproperty
   a_block: assert property (p_block) else $error("block repeat flag wrong"); // see [RULE9]

   property p_rel;
      s_plain_op(8'h18) ##1 (byte_valid && st_q == S_IMM_LO) |=> dec_valid_q &&
      dec_q.cls == CL_REL_BRANCH && dec_q.imm[7:0] == $past(byte_data);
   endproperty
   a_rel: assert property (p_rel) else $error("branch displacement wrong"); // see [RULE10]

   property p_restart;
      byte_valid && st_q == S_OP && byte_data[7:6] == 2'd3 && byte_data[2:0] == 3'd7
      |=> dec_valid_q && dec_q.rst_addr == {2'b00, $past(byte_data[5:3]), 3'b000};
   endproperty
   a_restart: assert property (p_restart) else $error("restart address wrong"); // see [RULE11]

   property p_mask;
      s_plain_op(`OCD_OP_MASKI) |=> dec_valid_q && dec_q.cls == CL_MASK_INTERRUPTS;
   endproperty
   a_mask: assert property (p_mask) else $error("mask decode wrong"); // see [RULE12]

   property p_imm16;
      s_plain_op(`OCD_OP_JP) ##1 s_imm_lo_then_hi |-> byte_valid |=> dec_valid_q;
   endproperty
   a_imm16: assert property (p_imm16) else $error("16-bit operand count wrong"); // see [RULE13]

   property p_port_n;
      s_plain_op(`OCD_OP_OUT_N) |=> !dec_valid_q && st_q == S_IMM_LO;
   endproperty
   a_port_n: assert property (p_port_n) else $error("port byte not expected"); // see [RULE14]

   property p_exchange;
      s_plain_op(`OCD_OP_EX_DE) |=> dec_valid_q && dec_q.cls == CL_EXCHANGE;
   endproperty
   a_exchange: assert property (p_exchange) else $error("exchange decode wrong"); // see [RULE15]

   property p_undef;
      byte_valid && st_q == S_BIT && byte_data[7:3] == 5'b00110 |=> dec_valid_q && dec_q.undef;
   endproperty
   a_undef: assert property (p_undef) else $error("undefined not flagged"); // see [RULE16]
endmodule

// file: tb/ocd_fetch_model.sv
`timescale 1ns/1ns
// ******************************
// fetch side model
// ******************************
module ocd_fetch_model
(
   input  wire logic       clk,
   output      logic       byte_valid,
   output      logic [7:0] byte_data
);
   initial
   begin
      byte_valid = 1'b0;
      byte_data  = 8'h5A;
   end

   // entered just after a rising edge; idle cycles scramble the data lines
   task automatic send(input logic [7:0] q[$], input logic gaps);
      foreach (q[i])
      begin
         if (gaps)
            repeat ($urandom_range(2))
            begin
               byte_valid = 1'b0;
               byte_data  = ~byte_data;
               @(posedge clk);
               #1;
            end
         byte_valid = 1'b1;
         byte_data  = q[i];
         @(posedge clk);
         #1;
      end
      byte_valid = 1'b0;
      byte_data  = ~byte_data;
   endtask
endmodule

// file: tb/tb_ocd_decoder.sv
`timescale 1ns/1ns
module tb_ocd_decoder;
   import ocd_pkg::*;
   logic       clk;
   logic       rstn;
   logic       byte_valid;
   logic [7:0] byte_data;
   logic       dec_valid_q;
   ocd_dec_t   dec_q;
   ocd_dec_t   got_q[$];
   ocd_dec_t   got;
   int         mismatches;
   int         checked;
   logic [7:0] b;
   logic [7:0] e;
   logic [7:0] rel_ops [6] = '{8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38};
   logic [7:0] xch_ops [4] = '{8'h08, 8'hD9, 8'hEB, 8'hE3};
   logic [7:0] irs_ops [3] = '{8'h46, 8'h56, 8'h5E};

   ocd_fetch_model i_ocd_fetch_model (.clk(clk), .byte_valid(byte_valid), .byte_data(byte_data));
   ocd_decoder i_ocd_decoder (.clk(clk), .rstn(rstn), .byte_valid(byte_valid), .byte_data(byte_data),
                              .dec_valid_q(dec_valid_q), .dec_q(dec_q));

   // ******************************
   // checking helpers
   // ******************************
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
      if (dec_valid_q === 1'b1)
         got_q.push_back(dec_q);

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic stop_test;
      if (mismatches == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // undefined results carry no promised class, so the class is not compared; pulses, flag and idx still are
   task automatic run(input logic [7:0] q[$], input ocd_cls_t cls, input ocd_idx_t idx, input logic undef);
      int n = 0;
      i_ocd_fetch_model.send(q, 1'($urandom_range(1)));
      while (got_q.size() == 0 && n < 8)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
      check("pulses", 16'(got_q.size()), 16'h0001);
      got = (got_q.size() > 0) ? got_q.pop_front() : '0;
      got_q.delete();
      check("undef", 16'(got.undef), 16'(undef));
      check("idx", 16'(got.idx), 16'(idx));
      if (!undef)
         check("cls", 16'(got.cls), 16'(cls));
   endtask

   function automatic ocd_cls_t bit_cls(input logic [7:0] op);
      case (op[7:6])
         2'h0: return CL_ROT_SHIFT;
         2'h1: return CL_BIT_TEST;
         2'h2: return CL_BIT_CLEAR;
         default: return CL_BIT_SET;
      endcase
   endfunction

   // ******************************
   // main sequence
   // ******************************
   initial
   begin
      mismatches = 0;
      checked    = 0;
      rstn       = 1'b0;
      void'($urandom(32'hC7E9C0F8));
      repeat (4) @(posedge clk);
      #1 rstn = 1'b1;
      @(posedge clk);
      #1;
      run('{8'h76}, CL_HALT, IDX_NONE, 1'b0);
      run('{8'h00}, CL_NO_OPERATION, IDX_NONE, 1'b0);
      repeat (8)
      begin
         b = 8'h40 | 8'($urandom_range(63));
         if (b == 8'h76)
            b = 8'h7F;
         run('{b}, CL_COPY, IDX_NONE, 1'b0);
         check("dst", 16'(got.sel), 16'(b[5:3]));
         check("src", 16'(got.src), 16'(b[2:0]));
         b = 8'h80 | 8'($urandom_range(63));
         run('{b}, CL_ALU, IDX_NONE, 1'b0);
         check("grp", 16'(got.sel), 16'(b[5:3]));
         check("opnd", 16'(got.src), 16'(b[2:0]));
         b = 8'($urandom);
         if (b[7:3] == 5'h06)
            b[3] = 1'b1;
         run('{8'hCB, b}, bit_cls(b), IDX_NONE, 1'b0);
         check("bitno", 16'(got.sel), 16'(b[5:3]));
         check("bitgrp", 16'(got.grp), 16'(GRP_BIT));
         check("bitop", 16'(got.opcode), 16'(b));
         e = 8'($urandom);
         run('{8'hDD, 8'h46, e}, CL_COPY, IDX_FIRST, 1'b0);
         check("disp", 16'(got.disp), 16'(e));
         run('{8'hFD, 8'h86, e}, CL_ALU, IDX_SECOND, 1'b0);
         check("disp", 16'(got.disp), 16'(e));
         run('{8'hDD, 8'h36, e, 8'h5B}, CL_OTHER, IDX_FIRST, 1'b0);
         check("dispn", 16'(got.disp), 16'(e));
         check("immn", got.imm, 16'h005B);
         // index bit forms need the memory operand; 36 is no shift
         b = {2'($urandom_range(3)), 3'($urandom_range(7)), 3'h6};
         if (b[7:3] == 5'h06)
            b[3] = 1'b1;
         run('{8'hFD, 8'hCB, e, b}, bit_cls(b), IDX_SECOND, 1'b0);
         check("idisp", 16'(got.disp), 16'(e));
         check("ibit", 16'(got.sel), 16'(b[5:3]));
         b = 8'hA0 | {3'h0, 2'($urandom_range(3)), 1'b0, 2'($urandom_range(3))};
         run('{8'hED, b}, CL_BLOCK, IDX_NONE, 1'b0);
         check("rpt", 16'(got.rpt), 16'(b[4]));
         check("extgrp", 16'(got.grp), 16'(GRP_EXT));
         run('{8'hCB, 8'h30 | 8'($urandom_range(7))}, CL_OTHER, IDX_NONE, 1'b1);
         run('{8'hED, 8'($urandom_range(63))}, CL_OTHER, IDX_NONE, 1'b1);
      end
      foreach (irs_ops[k])
      begin
         run('{8'hED, irs_ops[k]}, CL_RESPONSE_SELECT, IDX_NONE, 1'b0);
         check("mode", 16'(got.irs_mode), 16'(k));
      end
      run('{8'hDD, 8'hED, 8'h45}, CL_RET_NONMASKABLE, IDX_NONE, 1'b0);
      run('{8'hED, 8'h4D}, CL_RET_MASKABLE, IDX_NONE, 1'b0);
      run('{8'hC9}, CL_OTHER, IDX_NONE, 1'b0);
      run('{8'hED, 8'hA4}, CL_OTHER, IDX_NONE, 1'b1);
      run('{8'hDD, 8'hCB, 8'h11, 8'h47}, CL_OTHER, IDX_FIRST, 1'b1);
      foreach (rel_ops[k])
      begin
         e = 8'($urandom);
         run('{rel_ops[k], e}, CL_REL_BRANCH, IDX_NONE, 1'b0);
         check("rel", got.imm & 16'h00FF, 16'(e));
      end
      for (int k = 0; k < 8; k++)
      begin
         run('{8'hC7 | 8'(k << 3)}, CL_RESTART, IDX_NONE, 1'b0);
         check("vec", 16'(got.rst_addr), 16'(k * 8));
      end
      run('{8'hF3}, CL_MASK_INTERRUPTS, IDX_NONE, 1'b0);
      run('{8'hFB}, CL_UNMASK_INTERRUPTS, IDX_NONE, 1'b0);
      run('{8'h01, 8'h34, 8'hE2}, CL_OTHER, IDX_NONE, 1'b0);
      check("imm16", got.imm, 16'hE234);
      run('{8'hED, 8'h43, 8'h78, 8'h56}, CL_OTHER, IDX_NONE, 1'b0);
      check("eimm16", got.imm, 16'h5678);
      run('{8'h16, 8'h9C}, CL_OTHER, IDX_NONE, 1'b0);
      check("imm8", got.imm & 16'h00FF, 16'h009C);
      run('{8'hD3, 8'h7E}, CL_OUT_IMM_PORT, IDX_NONE, 1'b0);
      check("port", got.imm & 16'h00FF, 16'h007E);
      run('{8'hDB, 8'h81}, CL_IN_IMM_PORT, IDX_NONE, 1'b0);
      run('{8'hED, 8'h41}, CL_PORT_VIA_C, IDX_NONE, 1'b0);
      run('{8'hED, 8'h78}, CL_PORT_VIA_C, IDX_NONE, 1'b0);
      foreach (xch_ops[k])
         run('{xch_ops[k]}, CL_EXCHANGE, IDX_NONE, 1'b0);
      // back to back, no gaps: each instruction starts right after the last
      i_ocd_fetch_model.send('{8'h00, 8'h76, 8'h18, 8'h42, 8'hC3, 8'h34, 8'h12}, 1'b0);
      repeat (2) @(posedge clk);
      #1;
      check("b2b", 16'(got_q.size()), 16'h0004);
      if (got_q.size() == 4)
      begin
         check("b2b_halt", 16'(got_q[1].cls), 16'(CL_HALT));
         check("b2b_rel", got_q[2].imm, 16'h0042);
         check("b2b_jp", got_q[3].imm, 16'h1234);
      end
      got_q.delete();
      // a reset in mid-instruction must forget a pending prefix
      i_ocd_fetch_model.send('{8'hDD}, 1'b0);
      rstn = 1'b0;
      @(posedge clk);
      #1 rstn = 1'b1;
      run('{8'h46}, CL_COPY, IDX_NONE, 1'b0);
      stop_test();
   end

   initial
   begin
      #200000;
      mismatches++;
      stop_test();
   end
endmodule
